// *** src/vcp_pkg.sv ***
package vcp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int EXT_RESET_MIN_NS = 500;
  localparam int LOSS_TIMEOUT_NS = 20000;
  // least time, so round up
  localparam int LOSS_CYCLES_I   = (LOSS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOSS_CNT_W      = 9;
  localparam logic [LOSS_CNT_W-1:0] LOSS_CYCLES = LOSS_CNT_W'(LOSS_CYCLES_I);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TX_GAIN  = 8'h01;
  localparam logic [7:0] ADDR_MODE     = 8'h02;
  localparam logic [7:0] ADDR_STATUS   = 8'h03;

  localparam int PWR_BIT_UP      = 0;
  localparam int PWR_BIT_EARSEL  = 1;
  localparam int PWR_BIT_MICROPHONE_MUTE = 6;
  localparam int TXG_BIT_LOWPD   = 7;
  localparam int TXG_BIT_NORMAL  = 3;
  localparam int MODE_BIT_LINEAR = 0;
  localparam int MODE_BIT_ALAW   = 1;

  localparam logic [7:0] PWR_CTRL_RST = 8'h00;
  localparam logic [7:0] TX_GAIN_RST  = 8'h0b;
  localparam logic [1:0] MODE_RST     = 2'h0;

  localparam logic [2:0] PGA_STEP_MAX = 3'h5;

  // ----------------------------------------------------------------
  // pcm word
  // ----------------------------------------------------------------
  localparam int         PCM_W        = 15;
  localparam logic [3:0] LAST_LINEAR  = 4'he;
  localparam logic [3:0] LAST_COMPAND = 4'h7;
  localparam logic [7:0] MULAW_ZERO   = 8'hff;
  localparam logic [7:0] ALAW_ZERO    = 8'hd5;

  typedef enum logic [1:0] {
    PCM_IDLE  = 2'b00,
    PCM_ARMED = 2'b01,
    PCM_SHIFT = 2'b10
  } vcp_pcm_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vcp_bus_req_s;

  typedef struct packed {
    logic       powered_up;
    logic       diff_amp_en;
    logic       se_amp_en;
    logic       low_power_pd;
    logic       mic_mute;
    logic       amp2_extended;
    logic [2:0] pga_step;
  } vcp_ana_s;

  typedef struct packed {
    logic [7:0]            ctrl;
    logic [7:0]            txg;
    logic [1:0]            mode;
    logic [7:0]            rdata;
    logic                  pwr_up;
    logic                  clk_lost;
    logic                  mclk_prev;
    logic [LOSS_CNT_W-1:0] loss_cnt;
    logic                  bclk_prev;
    vcp_pcm_e              pcm;
    logic [3:0]            bit_cnt;
    logic [PCM_W-1:0]      tx_sh;
    logic [PCM_W-1:0]      rx_sh;
    logic [PCM_W-1:0]      rx_word;
    logic                  rx_valid;
    logic                  out;
    logic                  oe;
    vcp_ana_s              ana;
  } vcp_state_s;

endpackage : vcp_pkg

// *** src/vcp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module vcp_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vcp_sync_s;

  vcp_sync_s st_reg;
  vcp_sync_s st_next;

  // first stage feeds only the second
  always_comb begin
    st_next.s1 = d_async;
    st_next.s2 = st_reg.s1;
    if (srst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clock) begin
    st_reg <= st_next;
  end

  assign q = st_reg.s2;

endmodule : vcp_sync

`default_nettype wire

// *** src/vcp_top.sv ***
// Summary of operation
// - external reset loads every control register with its default.
// - all settings writable while powered down, before power-up.
// - powered up: ear select 1 enables differential amp, 0 single-ended.
// - power bit 0 clear powers down; gain bit 7 picks low-power variant.
// - master clock loss forces power-down and tristates pcm output.
// - power-down during a transmit word waits for the word to finish.
// - gain bit 7 set bypasses clock-loss detection for power-down.
// - linear mode exchanges 15-bit twos-complement words.
// - companded mode exchanges 8-bit mu-law or a-law codes.
// - power bit 6 mutes the transmit path.
// - transmit gain spans 41.5 to 19.5 dB, default 23.5 dB.
// - gain bit 3 clear extended, set normal; low bits pga in 2 dB steps.
// - pcm input sampled on falling bit-clock edge.
// - each pcm output bit launched after rising bit-clock edge.
// - output released after falling edge of the last bit.
// - words go msb first, 8 bits companded, 15 bits linear.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module vcp_top (
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic                  ext_reset_n,
  input  wire logic                  mclk_pin,
  input  wire logic                  pcm_bit_clock,
  input  wire logic                  pcm_frame_sync,
  input  wire logic                  pcm_serial_in,
  output logic                       pcm_serial_out,
  output logic                       pcm_serial_out_oe,
  input  wire vcp_pkg::vcp_bus_req_s bus_req,
  output logic [7:0]                 bus_rdata,
  input  wire logic [14:0]           tx_sample,
  output logic [14:0]                rx_word,
  output logic                       rx_valid,
  output vcp_pkg::vcp_ana_s          ana
);
  import vcp_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s;
  logic       rst_n_s;
  logic       mclk_s;
  logic       bclk_s;
  logic       fsync_s;
  logic       sin_s;

  vcp_sync #(.W(5)) u_sync (
    .clock   (clock),
    .srst    (srst),
    .d_async ({ext_reset_n, mclk_pin, pcm_bit_clock, pcm_frame_sync, pcm_serial_in}),
    .q       (pin_s)
  );

  assign rst_n_s = pin_s[4];
  assign mclk_s  = pin_s[3];
  assign bclk_s  = pin_s[2];
  assign fsync_s = pin_s[1];
  assign sin_s   = pin_s[0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  vcp_state_s st_reg;
  vcp_state_s st_next;

  logic             mclk_edge;
  logic             bclk_rise;
  logic             bclk_fall;
  logic             pd_req;
  logic [3:0]       last_idx;
  logic [PCM_W-1:0] load_word;
  logic [7:0]       zero_code;

  assign mclk_edge = mclk_s ^ st_reg.mclk_prev;
  assign bclk_rise = bclk_s & ~st_reg.bclk_prev;
  assign bclk_fall = ~bclk_s & st_reg.bclk_prev;

  always_comb begin
    st_next          = st_reg;
    st_next.rx_valid = 1'b0;
    st_next.rdata    = 8'h00;

    // ------------------------------------------------------------
    // master clock watchdog, timed by our own clock
    // ------------------------------------------------------------
    st_next.mclk_prev = mclk_s;
    if (mclk_edge) begin
      st_next.loss_cnt = '0;
      st_next.clk_lost = 1'b0;
    end else if (st_reg.loss_cnt != LOSS_CYCLES) begin
      st_next.loss_cnt = st_reg.loss_cnt + 1'b1;
    end else begin
      st_next.clk_lost = 1'b1;
    end

    // ------------------------------------------------------------
    // register port, open in any power state
    // ------------------------------------------------------------
    if (bus_req.wr) begin
      case (bus_req.addr)
        ADDR_PWR_CTRL: st_next.ctrl = bus_req.wdata;
        ADDR_TX_GAIN:  st_next.txg  = bus_req.wdata;
        ADDR_MODE:     st_next.mode = bus_req.wdata[1:0];
        default:       st_next.ctrl = st_reg.ctrl;
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_PWR_CTRL: st_next.rdata = st_reg.ctrl;
        ADDR_TX_GAIN:  st_next.rdata = st_reg.txg;
        ADDR_MODE:     st_next.rdata = {6'h00, st_reg.mode};
        ADDR_STATUS:   st_next.rdata = {5'h00, st_reg.oe, st_reg.clk_lost, st_reg.pwr_up};
        default:       st_next.rdata = 8'h00;
      endcase
    end

    // ------------------------------------------------------------
    // power sequencing
    // ------------------------------------------------------------
    // override bit makes the watchdog irrelevant
    pd_req = !st_reg.ctrl[PWR_BIT_UP]
           || (st_reg.clk_lost && !st_reg.txg[TXG_BIT_LOWPD]);
    // a word in flight is never cut short
    if (st_reg.pcm != PCM_SHIFT) begin
      st_next.pwr_up = !pd_req;
    end

    // ------------------------------------------------------------
    // pcm serial port
    // ------------------------------------------------------------
    st_next.bclk_prev = bclk_s;
    last_idx  = st_reg.mode[MODE_BIT_LINEAR] ? LAST_LINEAR : LAST_COMPAND;
    zero_code = st_reg.mode[MODE_BIT_ALAW] ? ALAW_ZERO : MULAW_ZERO;
    if (st_reg.mode[MODE_BIT_LINEAR]) begin
      // twos-complement zero when muted
      load_word = st_reg.ctrl[PWR_BIT_MICROPHONE_MUTE] ? '0 : tx_sample;
    end else begin
      // code left-justified so msb leads
      load_word = {(st_reg.ctrl[PWR_BIT_MICROPHONE_MUTE] ? zero_code : tx_sample[7:0]), 7'h00};
    end

    case (st_reg.pcm)
      PCM_IDLE: begin
        if (bclk_fall && fsync_s && st_reg.pwr_up) begin
          st_next.pcm = PCM_ARMED;
        end
      end
      PCM_ARMED: begin
        if (!st_reg.pwr_up) begin
          st_next.pcm = PCM_IDLE;
        end else if (bclk_rise) begin
          st_next.out     = load_word[PCM_W-1];
          st_next.tx_sh   = {load_word[PCM_W-2:0], 1'b0};
          st_next.oe      = 1'b1;
          st_next.bit_cnt = 4'h0;
          st_next.pcm     = PCM_SHIFT;
        end
      end
      PCM_SHIFT: begin
        if (bclk_rise) begin
          st_next.out   = st_reg.tx_sh[PCM_W-1];
          st_next.tx_sh = {st_reg.tx_sh[PCM_W-2:0], 1'b0};
        end
        if (bclk_fall) begin
          st_next.rx_sh = {st_reg.rx_sh[PCM_W-2:0], sin_s};
          if (st_reg.bit_cnt == last_idx) begin
            st_next.oe       = 1'b0;
            st_next.out      = 1'b0;
            st_next.pcm      = PCM_IDLE;
            st_next.rx_valid = 1'b1;
            st_next.rx_word  = st_reg.mode[MODE_BIT_LINEAR]
                             ? {st_reg.rx_sh[PCM_W-2:0], sin_s}
                             : {7'h00, st_reg.rx_sh[6:0], sin_s};
          end else begin
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end
        end
      end
      default: begin
        st_next.pcm = PCM_IDLE;
        st_next.oe  = 1'b0;
      end
    endcase

    // ------------------------------------------------------------
    // reset: block reset or synchronised external pin
    // ------------------------------------------------------------
    if (srst || !rst_n_s) begin
      st_next      = '0;
      st_next.ctrl = PWR_CTRL_RST;
      st_next.txg  = TX_GAIN_RST;
      st_next.mode = MODE_RST;
    end

    // ------------------------------------------------------------
    // analog controls, registered from the next state
    // ------------------------------------------------------------
    st_next.ana.powered_up    = st_next.pwr_up;
    st_next.ana.diff_amp_en   = st_next.pwr_up && st_next.ctrl[PWR_BIT_EARSEL];
    st_next.ana.se_amp_en     = st_next.pwr_up && !st_next.ctrl[PWR_BIT_EARSEL];
    st_next.ana.low_power_pd  = !st_next.pwr_up && st_next.txg[TXG_BIT_LOWPD];
    st_next.ana.mic_mute      = st_next.ctrl[PWR_BIT_MICROPHONE_MUTE];
    st_next.ana.amp2_extended = !st_next.txg[TXG_BIT_NORMAL];
    // unlisted codes clamp to the deepest step
    st_next.ana.pga_step      = (st_next.txg[2:0] > PGA_STEP_MAX)
                              ? PGA_STEP_MAX : st_next.txg[2:0];
  end

  always_ff @(posedge clock) begin
    st_reg <= st_next;
  end

  assign pcm_serial_out    = st_reg.out;
  assign pcm_serial_out_oe = st_reg.oe;
  assign bus_rdata         = st_reg.rdata;
  assign rx_word           = st_reg.rx_word;
  assign rx_valid          = st_reg.rx_valid;
  assign ana               = st_reg.ana;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence word_start_s;
    st_reg.pcm == PCM_ARMED && st_reg.pwr_up && bclk_rise;
  endsequence

  sequence word_end_s;
    st_reg.pcm == PCM_SHIFT && bclk_fall && st_reg.bit_cnt == last_idx;
  endsequence

  ext_reset_defaults_a: assert property (
    !rst_n_s |=> st_reg.ctrl == PWR_CTRL_RST && st_reg.txg == TX_GAIN_RST && !st_reg.pwr_up)
    else $error("control registers not at defaults after reset");

  write_while_down_a: assert property (
    bus_req.wr && bus_req.addr == ADDR_TX_GAIN && !st_reg.pwr_up && rst_n_s
    |=> st_reg.txg == $past(bus_req.wdata))
    else $error("write lost while powered down");

  amp_select_a: assert property (
    ana.powered_up |-> (ana.diff_amp_en == st_reg.ctrl[PWR_BIT_EARSEL])
                       && (ana.se_amp_en == !st_reg.ctrl[PWR_BIT_EARSEL]))
    else $error("wrong earpiece amplifier enabled");

  power_down_a: assert property (
    !st_reg.ctrl[PWR_BIT_UP] && st_reg.pcm != PCM_SHIFT && rst_n_s
    |=> !st_reg.pwr_up ##1 (ana.low_power_pd == st_reg.txg[TXG_BIT_LOWPD]))
    else $error("power down not taken");

  clock_loss_a: assert property (
    st_reg.clk_lost && !st_reg.txg[TXG_BIT_LOWPD] && st_reg.pcm == PCM_IDLE
    |=> !st_reg.pwr_up && !pcm_serial_out_oe)
    else $error("clock loss did not power down");

  word_kept_a: assert property (
    st_reg.pcm == PCM_SHIFT && rst_n_s |=> st_reg.pwr_up == $past(st_reg.pwr_up))
    else $error("power changed mid word");

  override_a: assert property (
    st_reg.txg[TXG_BIT_LOWPD] && st_reg.ctrl[PWR_BIT_UP] && st_reg.pcm != PCM_SHIFT && rst_n_s
    |=> st_reg.pwr_up)
    else $error("override ignored");

  mute_word_a: assert property (
    word_start_s and st_reg.ctrl[PWR_BIT_MICROPHONE_MUTE] && st_reg.mode[MODE_BIT_LINEAR] && rst_n_s
    |=> st_reg.tx_sh == '0 && !pcm_serial_out)
    else $error("muted word not zero");

  launch_rise_a: assert property (
    $rose(pcm_serial_out_oe) || ($changed(pcm_serial_out) && pcm_serial_out_oe)
    |-> $past(bclk_rise))
    else $error("output bit not launched on rising edge");

  release_fall_a: assert property (
    word_end_s and rst_n_s |=> !pcm_serial_out_oe && rx_valid)
    else $error("output not released after last bit");

  loss_timeout_a: assert property (
    st_reg.loss_cnt == LOSS_CYCLES && !mclk_edge && rst_n_s |=> st_reg.clk_lost)
    else $error("clock loss not declared");

  gain_default_a: assert property (
    $past(srst) |-> st_reg.txg == TX_GAIN_RST && ana.amp2_extended == 1'b0)
    else $error("gain not at default");

endmodule : vcp_top

`default_nettype wire

// *** bench/vcp_bb_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module vcp_bb_model (
  input  wire logic pcm_serial_out,
  input  wire logic pcm_serial_out_oe,
  output logic      pcm_bit_clock,
  output logic      pcm_frame_sync,
  output logic      pcm_serial_in
);
  // ----------------------------------------------------------------
  // baseband end of the pcm port
  // ----------------------------------------------------------------
  // bit clock stands low between frames; a released data line flips
  initial begin
    pcm_bit_clock  = 1'b0;
    pcm_frame_sync = 1'b0;
    pcm_serial_in  = 1'b0;
  end

  task automatic xfer(input int n, input logic [14:0] din, output logic [14:0] dout,
                      output logic oe_ok);
    dout           = '0;
    oe_ok          = 1'b1;
    pcm_frame_sync = 1'b1;
    #400 pcm_bit_clock = 1'b1;
    #400 pcm_bit_clock = 1'b0;
    #150 pcm_frame_sync = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #250 pcm_bit_clock = 1'b1;
      #100 pcm_serial_in = din[i];
      #300 pcm_bit_clock = 1'b0;
      // sampled before the device can have seen this fall
      #150 dout = {dout[13:0], pcm_serial_out};
      oe_ok &= pcm_serial_out_oe;
    end
    fork
      #250 pcm_serial_in = ~pcm_serial_in;
    join_none
  endtask : xfer
endmodule : vcp_bb_model

`default_nettype wire

// *** bench/test_vcp_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_vcp_top;
  import vcp_pkg::*;

  // ----------------------------------------------------------------
  // signals and reference state
  // ----------------------------------------------------------------
  logic         clock;
  logic         srst;
  logic         ext_reset_n;
  logic         mclk_pin;
  logic         mclk_run;
  logic         pcm_bit_clock;
  logic         pcm_frame_sync;
  logic         pcm_serial_in;
  logic         pcm_serial_out;
  logic         pcm_serial_out_oe;
  vcp_bus_req_s bus_req;
  logic [7:0]   bus_rdata;
  logic [14:0]  tx_sample;
  logic [14:0]  rx_word;
  logic         rx_valid;
  vcp_ana_s     ana;
  logic [7:0]   m_reg [3];
  logic [14:0]  pd_dout;
  logic         pd_ok;
  int           fail_count;
  int           cmp_count;

  vcp_top DUT (
    .clock(clock), .srst(srst), .ext_reset_n(ext_reset_n), .mclk_pin(mclk_pin),
    .pcm_bit_clock(pcm_bit_clock), .pcm_frame_sync(pcm_frame_sync),
    .pcm_serial_in(pcm_serial_in), .pcm_serial_out(pcm_serial_out),
    .pcm_serial_out_oe(pcm_serial_out_oe), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .tx_sample(tx_sample), .rx_word(rx_word), .rx_valid(rx_valid), .ana(ana));

  vcp_bb_model u_bb (
    .pcm_serial_out(pcm_serial_out), .pcm_serial_out_oe(pcm_serial_out_oe),
    .pcm_bit_clock(pcm_bit_clock), .pcm_frame_sync(pcm_frame_sync),
    .pcm_serial_in(pcm_serial_in));

  initial clock = 1'b0;
  always #50 clock = ~clock;
  always @(posedge clock) if (mclk_run) mclk_pin <= ~mclk_pin;

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
    if (a < 8'h03) m_reg[a] = d & ((a == 8'h02) ? 8'h03 : 8'hff);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    #1 chk({7'h0, bus_rdata}, {7'h0, exp});
  endtask : rd

  task automatic chk_ana;
    logic [8:0] e;
    logic       p;
    repeat (4) @(posedge clock);
    #1;
    p = m_reg[0][0];
    // mute level while powered down is left open
    e = {p, p & m_reg[0][1], p & ~m_reg[0][1], ~p & m_reg[1][7], p & m_reg[0][6],
         ~m_reg[1][3], (m_reg[1][2:0] > 3'h5) ? 3'h5 : m_reg[1][2:0]};
    chk({6'h0, ana & {4'hf, p, 4'hf}}, {6'h0, e});
  endtask : chk_ana

  task automatic word(input logic down_mid);
    logic [14:0] r, din, dout, es;
    logic        ok;
    int          n, k;
    n   = m_reg[2][0] ? 15 : 8;
    r   = 15'($urandom);
    din = 15'($urandom) & ((n == 15) ? 15'h7fff : 15'h00ff);
    es  = (n == 15) ? r : {7'h0, r[7:0]};
    if (m_reg[0][6]) es = (n == 15) ? 15'h0 : {7'h0, m_reg[2][1] ? ALAW_ZERO : MULAW_ZERO};
    @(posedge clock);
    tx_sample <= r;
    fork
      u_bb.xfer(n, din, dout, ok);
      if (down_mid) begin
        #3000 wr(ADDR_PWR_CTRL, m_reg[0] & 8'hfe);
        repeat (3) @(posedge clock);
        #1 chk({14'h0, ana.powered_up}, 15'h1);
      end
    join
    chk(dout, es);
    chk({14'h0, ok}, 15'h1);
    k = 0;
    while (rx_valid !== 1'b1 && k < 20) begin
      @(posedge clock);
      #1 k++;
    end
    chk({14'h0, rx_valid}, 15'h1);
    chk(rx_word, din);
    chk({14'h0, pcm_serial_out_oe}, 15'h0);
  endtask : word

  task automatic lose_mclk;
    @(posedge clock);
    mclk_run <= 1'b0;
    repeat (260) @(posedge clock);
  endtask : lose_mclk

  task automatic stop_test;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fail_count  = 0;
    cmp_count   = 0;
    srst        = 1'b1;
    ext_reset_n = 1'b1;
    mclk_pin    = 1'b0;
    mclk_run    = 1'b1;
    bus_req     = '0;
    tx_sample   = '0;
    m_reg       = '{8'h00, 8'h0b, 8'h00};
    void'($urandom(68));
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    for (int a = 0; a < 3; a++) rd(8'(a), m_reg[a]);
    rd(ADDR_STATUS, 8'h00);
    rd(8'h7f, 8'h00);
    chk_ana;
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_TX_GAIN, {1'($urandom), 3'h0, 4'(c)});
      rd(ADDR_TX_GAIN, m_reg[1]);
      chk_ana;
    end
    wr(ADDR_TX_GAIN, 8'h0b);
    for (int i = 0; i < 12; i++) begin
      wr(ADDR_MODE, (i % 3 == 0) ? 8'h01 : ((i % 3 == 1) ? 8'h00 : 8'h02));
      wr(ADDR_PWR_CTRL, {1'b0, 1'(i / 6), 4'h0, 1'(i / 3), 1'b1});
      chk_ana;
      word(1'b0);
      rd(ADDR_STATUS, 8'h01);
    end
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_TX_GAIN, 8'h80);
    word(1'b1);
    chk_ana;
    // frame offered while powered down must leave the output released
    u_bb.xfer(15, 15'h0, pd_dout, pd_ok);
    chk({14'h0, pd_ok}, 15'h0);
    wr(ADDR_TX_GAIN, 8'h0b);
    wr(ADDR_PWR_CTRL, 8'h01);
    lose_mclk;
    rd(ADDR_STATUS, 8'h02);
    chk({13'h0, ana.powered_up, pcm_serial_out_oe}, 15'h0);
    mclk_run <= 1'b1;
    repeat (10) @(posedge clock);
    rd(ADDR_STATUS, 8'h01);
    word(1'b0);
    wr(ADDR_TX_GAIN, 8'h8b);
    lose_mclk;
    #1 chk({14'h0, ana.powered_up}, 15'h1);
    mclk_run <= 1'b1;
    ext_reset_n <= 1'b0;
    repeat (EXT_RESET_MIN_NS / CLK_PERIOD_NS + 1) @(posedge clock);
    ext_reset_n <= 1'b1;
    repeat (5) @(posedge clock);
    m_reg = '{8'h00, 8'h0b, 8'h00};
    for (int a = 0; a < 3; a++) rd(8'(a), m_reg[a]);
    chk_ana;
    stop_test;
  end

  initial begin
    #5_000_000;
    fail_count++;
    stop_test;
  end
endmodule : test_vcp_top

`default_nettype wire
